// [hw/clr_copper_port_link_mode_resolver.sv]
`timescale 1ns/1ps
module clr_copper_port_link_mode_resolver (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        linkSignal,
  input  wire logic        negPulsesSeen,
  input  wire logic        idle10Seen,
  input  wire logic        idle100Seen,
  input  wire logic [3:0]  partnerAbility,
  input  wire logic        txActive,
  input  wire logic        rxActive,
  output logic             linkUpIndicator,
  output logic             trafficIndicator,
  output logic             duplexIndicator,
  output logic             speedIndicator,
  output logic             collisionOut,
  output logic             irq
);
  import clr_pkg::*;

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] syncA_r;
  logic [PIN_W-1:0] syncB_r;
  logic             linkS, negS, idle10S, idle100S, txS, rxS;
  logic [3:0]       abilityS;
  clr_state_t       state_r, state_nxt;
  clr_mode_t        mode_r, mode_nxt;
  logic             modeOk;
  logic [11:0]      settleCnt_r;
  logic [2:0]       ctrl_r;
  logic [3:0]       adv_r;
  logic [2:0]       irqStat_r;
  logic [2:0]       irqMask_r;
  logic [2:0]       irqEvt;
  logic             parallel_r;
  logic             addrPh, wrPend_r, rdClear;
  logic [7:0]       wrAddr_r;
  logic             restartReq;
  logic [3:0]       common;

  // every pin input passes two flops before logic sees it
  assign pinRaw = {partnerAbility, rxActive, txActive, idle100Seen, idle10Seen,
                   negPulsesSeen, linkSignal};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          syncA_r[gi] <= 1'b0;
          syncB_r[gi] <= 1'b0;
        end else begin
          syncA_r[gi] <= pinRaw[gi];
          syncB_r[gi] <= syncA_r[gi];
        end
      end
    end
  endgenerate
  assign {abilityS, rxS, txS, idle100S, idle10S, negS, linkS} = syncB_r;

  // bus: zero wait states, every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPh    = hsel && htrans[1] && hready;
  assign rdClear   = addrPh && !hwrite && (haddr[7:0] == IRQ_STAT_OFS);
  // a control write restarts resolution with the new settings
  assign restartReq = wrPend_r && (wrAddr_r == CTRL_OFS);

  // write data arrives one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPend_r <= addrPh && hwrite;
      wrAddr_r <= haddr[7:0];
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= CTRL_RST;   // auto-negotiation by default
      adv_r     <= ADV_RST;
      irqMask_r <= IRQ_MASK_RST;
    end else if (wrPend_r) begin
      case (wrAddr_r)
        CTRL_OFS:     ctrl_r    <= hwdata[2:0];
        ADV_OFS:      adv_r     <= hwdata[3:0];
        IRQ_MASK_OFS: irqMask_r <= hwdata[2:0];
        default:      ;
      endcase
    end
  end

  // read data is prepared at the address phase so it stands in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (addrPh && !hwrite) begin
      case (haddr[7:0])
        CTRL_OFS:     hrdata <= {29'h0, ctrl_r};
        ADV_OFS:      hrdata <= {28'h0, adv_r};
        STAT_OFS:     hrdata <= {25'h0, state_r, parallel_r, mode_r, 1'b0, linkUpIndicator};
        IRQ_STAT_OFS: hrdata <= {29'h0, irqStat_r};
        IRQ_MASK_OFS: hrdata <= {29'h0, irqMask_r};
        PDV_OFS:      hrdata <= 32'(PATH_DELAY_BT);
        default:      hrdata <= 32'h0;
      endcase
    end
  end

  // highest common mode; in negotiation a mode is usable only if both ends advertise it
  assign common = adv_r & abilityS;
  always_comb begin
    mode_nxt = MODE_10H;
    modeOk   = 1'b1;
    if (!ctrl_r[CTRL_AUTONEG_BIT]) begin
      // fixed: speed and duplex straight from configuration
      mode_nxt = clr_mode_t'({ctrl_r[CTRL_SPD100_BIT], ctrl_r[CTRL_FULL_BIT]});
    end else if (negS) begin
      if (common[3])      mode_nxt = MODE_100F;
      else if (common[2]) mode_nxt = MODE_100H;
      else if (common[1]) mode_nxt = MODE_10F;
      else if (common[0]) mode_nxt = MODE_10H;
      else                modeOk   = 1'b0;
    end else if (idle100S) begin
      mode_nxt = MODE_100H;
    end else if (idle10S) begin
      mode_nxt = MODE_10H;
    end else begin
      modeOk = 1'b0;
    end
  end

  // link state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_DOWN:    if (linkS) state_nxt = ST_SETTLE;
      ST_SETTLE:  if (!linkS) state_nxt = ST_DOWN;
                  else if (settleCnt_r == 12'(SETTLE_CYC)) state_nxt = ST_RESOLVE;
      ST_RESOLVE: if (!linkS) state_nxt = ST_DOWN;
                  else if (modeOk) state_nxt = ST_UP;
      ST_UP:      if (!linkS) state_nxt = ST_DOWN;
      default:    state_nxt = ST_DOWN;
    endcase
    if (restartReq) begin
      state_nxt = ST_DOWN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_DOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // settle timer lets the partner finish its pulses before the choice is made
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt_r <= 12'h0;
    end else if (state_r != ST_SETTLE) begin
      settleCnt_r <= 12'h0;
    end else begin
      settleCnt_r <= settleCnt_r + 12'h1;
    end
  end

  // resolved mode is captured on entering the up state and kept there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r     <= MODE_10H;
      parallel_r <= 1'b0;
    end else if (state_r == ST_RESOLVE && state_nxt == ST_UP) begin
      mode_r     <= mode_nxt;
      parallel_r <= ctrl_r[CTRL_AUTONEG_BIT] && !negS;
    end
  end

  // indicators follow the up state and the synchronised carrier, so a loss clears them at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkUpIndicator  <= 1'b0;
      trafficIndicator <= 1'b0;
      duplexIndicator  <= 1'b0;
      speedIndicator   <= 1'b0;
    end else if (state_r == ST_UP && linkS) begin
      linkUpIndicator  <= 1'b1;
      trafficIndicator <= txS || rxS;
      duplexIndicator  <= mode_r[0];
      speedIndicator   <= mode_r[1];
    end else begin
      linkUpIndicator  <= 1'b0;
      trafficIndicator <= 1'b0;
      duplexIndicator  <= 1'b0;
      speedIndicator   <= 1'b0;
    end
  end

  // collision echo in half duplex: three cycles from pin, far under the delay budget
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      collisionOut <= 1'b0;
    end else begin
      // gated by carrier too, so a loss never leaves an echo without a link
      collisionOut <= (state_r == ST_UP) && linkS && !mode_r[0] && txS && rxS;
    end
  end

  // events: link up, link down, mode differing from the previous resolution
  assign irqEvt[IRQ_UP_BIT]   = (state_r != ST_UP) && (state_nxt == ST_UP);
  assign irqEvt[IRQ_DOWN_BIT] = (state_r == ST_UP) && (state_nxt != ST_UP);
  assign irqEvt[IRQ_MODE_BIT] = irqEvt[IRQ_UP_BIT] && (mode_nxt != mode_r);

  // sticky status, cleared by reading it; a new event in the same cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= 3'h0;
    end else begin
      irqStat_r <= (rdClear ? 3'h0 : irqStat_r) | irqEvt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r & irqMask_r);
    end
  end

endmodule // clr_copper_port_link_mode_resolver

// [hw/clr_pkg.sv]
package clr_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] ADV_OFS      = 8'h04;
  localparam logic [7:0] STAT_OFS     = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] PDV_OFS      = 8'h14;
  // control field positions
  localparam int CTRL_AUTONEG_BIT = 0;
  localparam int CTRL_SPD100_BIT  = 1;
  localparam int CTRL_FULL_BIT    = 2;
  localparam int CTRL_RESTART_BIT = 3;
  // interrupt field positions
  localparam int IRQ_UP_BIT       = 0;
  localparam int IRQ_DOWN_BIT     = 1;
  localparam int IRQ_MODE_BIT     = 2;
  // reset values
  localparam logic [2:0] CTRL_RST     = 3'h3;
  localparam logic [3:0] ADV_RST      = 4'hf;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // link modes, ranked: higher code is the better mode
  typedef enum logic [1:0] {
    MODE_10H  = 2'b00,
    MODE_10F  = 2'b01,
    MODE_100H = 2'b10,
    MODE_100F = 2'b11
  } clr_mode_t;
  typedef enum logic [1:0] {
    ST_DOWN    = 2'b00,
    ST_SETTLE  = 2'b01,
    ST_RESOLVE = 2'b10,
    ST_UP      = 2'b11
  } clr_state_t;
  // timing
  localparam int CLK_NS         = 8;
  localparam int BIT_TIME_NS    = 10;
  localparam int PATH_DELAY_BT  = 50;
  localparam int PATH_DELAY_CYC = (PATH_DELAY_BT * BIT_TIME_NS) / CLK_NS;
  localparam int SETTLE_NS      = 2000;
  localparam int SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIN_W          = 10;
endpackage

// [sim/clr_asserts.sv]
`timescale 1ns/1ps
module clr_asserts
  import clr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        linkSignal,
  input wire logic        txActive,
  input wire logic        rxActive,
  input wire logic        linkUpIndicator,
  input wire logic        trafficIndicator,
  input wire logic        duplexIndicator,
  input wire logic        speedIndicator,
  input wire logic        collisionOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] upCnt_r;
  logic       rdReq;
  // a read address phase that the slave takes
  assign rdReq = hsel && htrans[1] && hready && !hwrite;
  // carrier age in cycles; saturates so a long link never wraps back under the settle time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) upCnt_r <= 10'h0;
    else if (!linkSignal) upCnt_r <= 10'h0;
    else if (upCnt_r != 10'h3ff) upCnt_r <= upCnt_r + 10'h1;
  end
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero wait okay");
  a_settle_wait: assert property ($rose(linkUpIndicator) |-> upCnt_r >= 10'd250)
    else $error("link indicator rose before settle time");
  a_loss_clear: assert property ((!linkSignal)[*5] |=>
    !(linkUpIndicator || trafficIndicator || duplexIndicator || speedIndicator))
    else $error("indicators not cleared after link loss");
  a_mode_gated: assert property (!linkUpIndicator |-> !duplexIndicator && !speedIndicator)
    else $error("mode indicator on without link");
  a_traffic_lag: assert property (linkUpIndicator && $past(linkUpIndicator, 4)
    |-> trafficIndicator == $past(txActive || rxActive, 3))
    else $error("traffic indicator does not follow activity");
  a_coll_half: assert property (collisionOut |-> linkUpIndicator && !duplexIndicator)
    else $error("collision outside half duplex link");
  a_coll_delay: assert property ((linkUpIndicator && !duplexIndicator
    && txActive && rxActive)[*5] |-> collisionOut)
    else $error("collision echo too slow");
  a_pdv_read: assert property (rdReq && haddr[7:0] == PDV_OFS |=> hrdata == 32'h32)
    else $error("path delay register not 50");
  a_unmapped_zero: assert property (rdReq && haddr[7:0] == 8'h18 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // clr_asserts
bind clr_copper_port_link_mode_resolver clr_asserts chk_u (.*);

// [sim/clr_partner.sv]
`timescale 1ns/1ps
module clr_partner (
  input  wire logic       clk,
  input  wire logic       linkOn,
  input  wire logic       pulsesOn,
  input  wire logic [3:0] ability,
  input  wire logic       idle10,
  input  wire logic       idle100,
  input  wire logic       busy,
  output logic            linkSignal,
  output logic            negPulsesSeen,
  output logic            idle10Seen,
  output logic            idle100Seen,
  output logic      [3:0] partnerAbility,
  output logic            rxActive
);
  initial begin
    {linkSignal, negPulsesSeen, idle10Seen, idle100Seen, rxActive} = 5'h0;
    partnerAbility = 4'h5;
  end
  // dead cable: ability lines toggle so a stale value never reads as a real offer
  always @(posedge clk) begin
    linkSignal     <= linkOn;
    negPulsesSeen  <= linkOn && pulsesOn;
    idle10Seen     <= linkOn && !pulsesOn && idle10;
    idle100Seen    <= linkOn && !pulsesOn && idle100;
    partnerAbility <= linkOn ? ability : ~partnerAbility;
    rxActive       <= linkOn && busy;
  end
endmodule // clr_partner

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import clr_pkg::*;
  logic        clk, rst_n, hsel, hwrite, txActive, linkOn, pulsesOn, idle10, idle100, busy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0]  ability, partnerAbility;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, negPulsesSeen, idle10Seen, idle100Seen, rxActive, linkSignal;
  logic        linkUpIndicator, trafficIndicator, duplexIndicator, speedIndicator;
  logic        collisionOut, irq, maskOn;
  wire logic   hready;
  integer      seed;
  int          err_count, checks;
  int          lastPar;  // parallel-detect flag is kept from the last resolution
  clr_copper_port_link_mode_resolver dut_u (.*);
  clr_partner far_u (.*);
  assign hready = hreadyout;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // configure, raise the cable, compare against the mode model, then drop it
  task automatic run(input int an, spd, full, adv, pul, i10, i100, ab);
    int m, lk, n, c;
    c = adv & ab & 15;
    lk = 1;
    m = 0;
    if (an == 0) m = spd * 2 + full;
    else if (pul != 0) begin
      m = 3;
      while (m >= 0 && !c[m]) m--;
      lk = m >= 0;
    end
    else if (i100 != 0) m = 2;
    else if (i10 != 0) m = 0;
    else lk = 0;
    bus(1'b1, CTRL_OFS, {29'h0, full[0], spd[0], an[0]});
    bus(1'b1, ADV_OFS, adv);
    pulsesOn <= pul[0];
    idle10   <= i10[0];
    idle100  <= i100[0];
    ability  <= ab[3:0];
    linkOn   <= 1'b1;
    for (n = 0; n < 400 && linkUpIndicator !== 1'b1; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(linkUpIndicator, lk);
    chk(speedIndicator, lk && m > 1);
    chk(duplexIndicator, lk && m[0]);
    chk(irq, lk && maskOn);
    bus(1'b0, STAT_OFS, 32'h0);
    chk(rd[0], lk);
    if (lk) chk(rd[3:2], m);
    if (lk) lastPar = (an != 0) && (pul == 0);
    chk(rd[4], lastPar);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    chk(rd[0], lk);
    @(posedge clk);
    chk(irq, 1'b0);
    txActive <= 1'b1;
    busy     <= 1'b1;
    repeat (8) @(posedge clk);
    chk(trafficIndicator, lk);
    chk(collisionOut, lk && !m[0]);
    txActive <= 1'b0;
    busy     <= 1'b0;
    linkOn   <= 1'b0;
    repeat (8) @(posedge clk);
    chk({linkUpIndicator, trafficIndicator, duplexIndicator, speedIndicator}, 0);
    $display("run done: mode %0d link %0d", m, lk);
  endtask
  // hang guard, well beyond the fourteen runs of at most some 430 cycles each
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    {hsel, hwrite, txActive, linkOn, pulsesOn, idle10, idle100, busy, maskOn} = 9'h0;
    {haddr, hwdata, ability, htrans} = 0;
    hsize = 3'h2;
    seed = 32'h63b05512;
    err_count = 0;
    checks = 0;
    lastPar = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h3);
    bus(1'b0, ADV_OFS, 32'h0);
    chk(rd, 32'hf);
    bus(1'b0, IRQ_MASK_OFS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, PDV_OFS, 32'h0);
    chk(rd, 32'h32);
    bus(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    $display("reset values done");
    run(1, 1, 0, 15, 1, 0, 0, 4);
    bus(1'b1, IRQ_MASK_OFS, 32'h1);
    maskOn = 1'b1;
    repeat (4) run(1, 0, 0, 15, 1, 0, 0, $random(seed));
    repeat (2) run(1, 0, 0, $random(seed) & 15, 1, 0, 0, $random(seed));
    run(1, 0, 0, 15, 0, 0, 1, 0);
    run(1, 0, 0, 15, 0, 1, 0, 0);
    run(1, 0, 0, 15, 0, 0, 0, 0);
    for (int s = 0; s < 4; s++) run(0, s / 2, s % 2, 15, 1, 0, 0, 15);
    close_out();
  end
endmodule // testbench
